/* rtl/ipa_pkg.sv */
/*
  Shared types and constants for the interrupt priority arbiter.
  Assumes one 50 MHz system clock and an AHB-Lite register port.
*/
package ipa_pkg;
  localparam int          NUM_LEVELS   = 7;
  localparam int          ARB_W        = 4;
  localparam int          NUM_MODULES  = 4;
  localparam logic [2:0]  MASK_RESET   = 3'h7;
  localparam logic [2:0]  LEVEL_TOP    = 3'h7;
  localparam logic [2:0]  LEVEL_NONE   = 3'h0;
  localparam logic [3:0]  ARB_SIU_RST  = 4'hF;
  localparam logic [3:0]  ARB_MOD_RST  = 4'h0;
  localparam logic [3:0]  ARB_NONE     = 4'h0;
  localparam logic [2:0]  FC_CPU_SPACE = 3'h7;
  localparam logic [19:0] ADDR_HI_ONES = 20'hFFFFF;
  localparam logic [7:0]  AUTOVEC_BASE = 8'h18;
  localparam logic [7:0]  SPURIOUS_VEC = 8'h0F;
  localparam int          FILTER_PERIODS = 2;
  localparam int          BUS_TIMEOUT_NS = 320;
  localparam int          CLOCK_NS       = 20;
  localparam int          BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLOCK_NS;
  // Register byte addresses
  localparam logic [7:0]  OFS_CCR     = 8'h00;
  localparam logic [7:0]  OFS_PERCTL  = 8'h04;
  localparam logic [7:0]  OFS_ARB     = 8'h08;
  localparam logic [7:0]  OFS_PEND    = 8'h0C;
  localparam logic [7:0]  OFS_STATUS  = 8'h10;
  localparam int          MASK_LSB    = 5;
  localparam int          MONEN_BIT   = 0;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

  typedef enum logic [2:0] {
    IPA_IDLE    = 3'b000,
    IPA_ARB     = 3'b001,
    IPA_INTWAIT = 3'b010,
    IPA_EXTWAIT = 3'b011,
    IPA_DONE    = 3'b100
  } ipa_state_e;

  typedef struct packed {
    logic [2:0]  fc;
    logic [23:0] addr;
    logic        valid;
  } ipa_ack_cycle_s;

  typedef struct packed {
    logic [7:0] vector;
    logic       spurious;
    logic       autovec;
    logic       busErr;
  } ipa_result_s;
endpackage

/* rtl/ipa_arbiter.sv */
/*
  Interrupt priority arbiter: request filtering, masking, acknowledge
  cycle and serial arbitration-priority contention, with AHB-Lite registers.
  Assumes synchronous request inputs and an outside sequencer that pulses
  boundary when an instruction boundary is reached.
*/
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
// Contract
// - Seven request levels one to seven, level seven highest.
// - Three-bit mask in condition code bits 7:5; levels at or below are ignored.
// - Level seven is always recognised, even with mask seven.
// - Requests are active-low levels, held until acknowledged at that level.
// - Level seven is taken only on a falling edge, once per assertion.
// - Any mask write while level seven is low makes a new level-seven request.
// - A request is valid only after two consecutive low clock periods.
// - Valid requests wait pending until an instruction boundary.
// - Level is not latched; highest unmasked pending level wins at service.
// - Acknowledge drives level on address, starts read, copies level to mask.
// - Same-level contenders arbitrate by unique nonzero four-bit priority fields.
// - Winning source with zero arbitration priority gives a spurious exception.
// - Integration unit priority resets to 1111, all others to 0000.
// - Arbitration always runs; external bus only if unit wins; none ends in error.
// - A winning internal module ends the cycle with its own vector.
// - No timely external answer with monitor enabled gives bus error, spurious.
// - Chip-select answers never apply to internal module acknowledges.
// - Periodic level field sets timer level; zero disables it.
// - Same-level unit sources: periodic timer first, then external pins.
// - Reset loads the mask with seven.
// - Acknowledge drives function code ones, address ones, level on bits 3:1.
// - Autovector request yields an autovector number for the acknowledged level.
module ipa_arbiter
  import ipa_pkg::*;
#(
  parameter int NUM_MOD = ipa_pkg::NUM_MODULES,
  parameter int TIMEOUT = ipa_pkg::BUS_TIMEOUT_CYC
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hsel,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic [7:1]                extIrq_n,
  input  wire logic [NUM_MOD-1:0][2:0]   modLevel,
  input  wire logic [NUM_MOD-1:0][7:0]   modVector,
  input  wire logic                      periodicReq,
  input  wire logic [7:0]                periodicVector,
  input  wire logic                      boundary,
  input  wire logic                      extSizeAck,
  input  wire logic                      autovectorRequest,
  input  wire logic [7:0]                extData,
  output ipa_ack_cycle_s                 ackCycle,
  output ipa_result_s                    result,
  output logic                           resultValid,
  output logic [NUM_MOD-1:0]             modWin,
  output logic [7:1]                     pendingLevels,
  output logic [2:0]                     priorityMask
);
  import ipa_pkg::*;

  logic [7:1]             lowPrev;
  logic [7:1]             validLvl;
  logic                   topPrev;
  logic                   topEvent;
  logic [7:1]             levelReq;
  logic [2:0]             bestLevel;
  logic                   recog;
  logic [NUM_MOD-1:0][3:0] modArb;
  logic [3:0]             siuArb;
  logic [2:0]             periodicLevel;
  logic                   monEnable;
  ipa_state_e             state;
  logic [2:0]             ackLevel;
  logic [$clog2(TIMEOUT+1)-1:0] waitCnt;
  logic                   bWrite;
  logic [7:0]             bAddr;
  logic                   maskWrite;
  logic [3:0]             winArb;
  logic [NUM_MOD-1:0]     next_modWin;
  logic                   siuWins;
  logic                   siuContends;
  logic                   periodicAtLvl;

  // Two-period filter: valid once low on two successive samples
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lowPrev  <= '0;
      validLvl <= '0;
    end else begin
      lowPrev  <= ~extIrq_n;
      validLvl <= lowPrev & ~extIrq_n;
    end
  end

  // Level seven edge latch: one event per fresh assertion or mask write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      topPrev  <= 1'b0;
      topEvent <= 1'b0;
    end else begin
      topPrev <= validLvl[7];
      if ((validLvl[7] && !topPrev) || (maskWrite && validLvl[7])) begin
        topEvent <= 1'b1;
      end else if (state == IPA_ARB && ackLevel == LEVEL_TOP) begin
        topEvent <= 1'b0;
      end
    end
  end

  // Combine external pins, periodic timer and modules into level requests
  always_comb begin
    levelReq = validLvl;
    levelReq[7] = topEvent;
    if (periodicReq && periodicLevel != LEVEL_NONE) begin
      levelReq[periodicLevel] = 1'b1;
    end
    for (int m = 0; m < NUM_MOD; m++) begin
      if (modLevel[m] != LEVEL_NONE) begin
        levelReq[modLevel[m]] = 1'b1;
      end
    end
  end

  // Highest unmasked level, never latched while pending
  always_comb begin
    bestLevel = LEVEL_NONE;
    for (int l = 1; l <= NUM_LEVELS; l++) begin
      if (levelReq[l] && (3'(l) > priorityMask || 3'(l) == LEVEL_TOP)) begin
        bestLevel = 3'(l);
      end
    end
    recog = bestLevel != LEVEL_NONE;
  end

  // Serial contention resolved as the largest field among contenders
  always_comb begin
    periodicAtLvl = periodicReq && periodicLevel == ackLevel && periodicLevel != LEVEL_NONE;
    siuContends   = validLvl[ackLevel] || periodicAtLvl ||
                    (ackLevel == LEVEL_TOP && topEvent);
    winArb        = siuContends ? siuArb : ARB_NONE;
    next_modWin   = '0;
    for (int m = 0; m < NUM_MOD; m++) begin
      if (modLevel[m] == ackLevel && modArb[m] > winArb) begin
        winArb = modArb[m];
      end
    end
    siuWins = siuContends && winArb == siuArb && siuArb != ARB_NONE;
    for (int m = 0; m < NUM_MOD; m++) begin
      if (!siuWins && modLevel[m] == ackLevel && modArb[m] == winArb &&
          winArb != ARB_NONE) begin
        next_modWin[m] = 1'b1;
      end
    end
  end

  // Acknowledge sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state       <= IPA_IDLE;
      ackLevel    <= LEVEL_NONE;
      ackCycle    <= '0;
      result      <= '0;
      resultValid <= 1'b0;
      modWin      <= '0;
      waitCnt     <= '0;
    end else begin
      resultValid <= 1'b0;
      case (state)
        IPA_IDLE: begin
          if (boundary && recog) begin
            ackLevel       <= bestLevel;
            ackCycle.fc    <= FC_CPU_SPACE;
            ackCycle.addr  <= {ADDR_HI_ONES, bestLevel, 1'b1};
            ackCycle.valid <= 1'b1;
            state          <= IPA_ARB;
          end
        end
        IPA_ARB: begin
          modWin  <= next_modWin;
          waitCnt <= '0;
          if (siuWins) begin
            state <= IPA_EXTWAIT;
          end else if (next_modWin != '0) begin
            state <= IPA_INTWAIT;
          end else begin
            result      <= '{SPURIOUS_VEC, 1'b1, 1'b0, 1'b1};
            resultValid <= 1'b1;
            state       <= IPA_DONE;
          end
        end
        IPA_INTWAIT: begin
          result.vector   <= modVector[winIdx(modWin)];
          result.spurious <= 1'b0;
          result.autovec  <= 1'b0;
          result.busErr   <= 1'b0;
          resultValid     <= 1'b1;
          state           <= IPA_DONE;
        end
        IPA_EXTWAIT: begin
          waitCnt <= waitCnt + 1'b1;
          if (periodicAtLvl) begin
            result      <= '{periodicVector, 1'b0, 1'b0, 1'b0};
            resultValid <= 1'b1;
            state       <= IPA_DONE;
          end else if (autovectorRequest) begin
            result      <= '{AUTOVEC_BASE + 8'(ackLevel), 1'b0, 1'b1, 1'b0};
            resultValid <= 1'b1;
            state       <= IPA_DONE;
          end else if (extSizeAck) begin
            result      <= '{extData, 1'b0, 1'b0, 1'b0};
            resultValid <= 1'b1;
            state       <= IPA_DONE;
          end else if (monEnable && waitCnt >= ($bits(waitCnt))'(TIMEOUT - 1)) begin
            result      <= '{SPURIOUS_VEC, 1'b1, 1'b0, 1'b1};
            resultValid <= 1'b1;
            state       <= IPA_DONE;
          end
        end
        IPA_DONE: begin
          ackCycle <= '0;
          modWin   <= '0;
          state    <= IPA_IDLE;
        end
        default: state <= IPA_IDLE;
      endcase
    end
  end

  function automatic int winIdx(input logic [NUM_MOD-1:0] w);
    int idx;
    idx = 0;
    for (int m = 0; m < NUM_MOD; m++) begin
      if (w[m]) begin
        idx = m;
      end
    end
    return idx;
  endfunction

  assign pendingLevels = validLvl;

  // AHB-Lite slave, zero wait states
  assign maskWrite = bWrite && bAddr == OFS_CCR;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bWrite    <= 1'b0;
      bAddr     <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      bWrite    <= hsel && hready && htrans == HTRANS_NSEQ && hwrite;
      if (hsel && hready && htrans == HTRANS_NSEQ) begin
        bAddr <= haddr[7:0];
      end
    end
  end

  // Mask: reset to seven, copied from acknowledged level, software write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      priorityMask <= MASK_RESET;
    end else if (state == IPA_ARB) begin
      priorityMask <= ackLevel;
    end else if (maskWrite) begin
      priorityMask <= hwdata[MASK_LSB+2:MASK_LSB];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      siuArb        <= ARB_SIU_RST;
      modArb        <= {NUM_MOD{ARB_MOD_RST}};
      periodicLevel <= LEVEL_NONE;
      monEnable     <= 1'b0;
    end else if (bWrite) begin
      case (bAddr)
        OFS_PERCTL: begin
          periodicLevel <= hwdata[2:0];
          monEnable     <= hwdata[MONEN_BIT + 8];
        end
        OFS_ARB: begin
          siuArb <= hwdata[3:0];
          for (int m = 0; m < NUM_MOD; m++) begin
            modArb[m] <= hwdata[4*m+4 +: 4];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else begin
      case (haddr[7:0])
        OFS_CCR:    hrdata <= 32'({priorityMask, 5'h00});
        OFS_PERCTL: hrdata <= 32'({monEnable, 5'h00, periodicLevel});
        OFS_ARB:    hrdata <= 32'({modArb, siuArb});
        OFS_PEND:   hrdata <= 32'({validLvl, 1'b0});
        OFS_STATUS: hrdata <= 32'({ackLevel, 5'h00, state});
        default:    hrdata <= 32'h00000000;
      endcase
    end
  end

  mask_reset_a: assert property (@(posedge clock) $rose(rst_n) |-> priorityMask == MASK_RESET)
    else $error("mask not seven after reset");
  filter_two_a: assert property (@(posedge clock) disable iff (!rst_n)
    !extIrq_n[1] ##1 !extIrq_n[1] |=> pendingLevels[1])
    else $error("two-period request not pending");
  filter_short_a: assert property (@(posedge clock) disable iff (!rst_n)
    extIrq_n[2] ##1 !extIrq_n[2] ##1 extIrq_n[2] |-> !pendingLevels[2])
    else $error("one-period request became pending");
  ack_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
    state == IPA_ARB |-> ackCycle.addr[3:1] == ackLevel && ackCycle.fc == FC_CPU_SPACE)
    else $error("acknowledge address wrong");
  mask_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
    state == IPA_ARB |=> priorityMask == $past(ackLevel))
    else $error("mask not loaded from level");
  mask_block_a: assert property (@(posedge clock) disable iff (!rst_n)
    state == IPA_IDLE && boundary && recog |-> bestLevel > priorityMask || bestLevel == LEVEL_TOP)
    else $error("masked level recognised");
  no_contend_a: assert property (@(posedge clock) disable iff (!rst_n)
    state == IPA_ARB && !siuWins && next_modWin == '0 |=> resultValid && result.busErr)
    else $error("no contender without bus error");
  autovec_a: assert property (@(posedge clock) disable iff (!rst_n)
    state == IPA_EXTWAIT && !periodicAtLvl && autovectorRequest
    |=> result.autovec && result.vector == AUTOVEC_BASE + 8'($past(ackLevel)))
    else $error("autovector number wrong");
  top_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
    validLvl[7] && !topPrev |=> topEvent)
    else $error("level seven edge missed");
endmodule

/* tb/ipa_req_model.sv */
/*
  Requester model: external request pins and internal modules.
  Assumes the bench sets levels with go and picks the answer mode.
*/
`timescale 1ns/10ps
module ipa_req_model
  import ipa_pkg::*;
(
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  input  wire logic                                go,
  input  wire logic                                dropAll,
  input  wire logic [7:1]                          raise,
  input  wire logic [ipa_pkg::NUM_MODULES-1:0][2:0] modSet,
  input  wire logic [1:0]                          mode,
  input  wire logic [2:0]                          dly,
  input  wire logic [7:0]                          extVec,
  input  wire ipa_pkg::ipa_ack_cycle_s             ackCycle,
  input  wire logic                                resultValid,
  input  wire logic [ipa_pkg::NUM_MODULES-1:0]     modWin,
  output logic      [7:1]                          extIrq_n,
  output logic      [ipa_pkg::NUM_MODULES-1:0][2:0] modLevel,
  output logic      [ipa_pkg::NUM_MODULES-1:0][7:0] modVector,
  output logic                                     extSizeAck,
  output logic                                     autovectorRequest,
  output logic      [7:0]                          extData
);
  import ipa_pkg::*;
  logic [7:1] held;
  logic [2:0] cnt;
  logic       lost;
  logic [2:0] lvl;
  assign lvl       = ackCycle.addr[3:1];
  assign extIrq_n  = ~held;
  assign modVector = {8'hA3, 8'hA2, 8'hA1, 8'hA0};
  always_ff @(posedge clock) begin
    if (!rst_n || dropAll) begin
      held              <= 7'h00;
      modLevel          <= '0;
      cnt               <= 3'h0;
      lost              <= 1'b0;
      extSizeAck        <= 1'b0;
      autovectorRequest <= 1'b0;
      extData           <= 8'h00;
    end else begin
      if (go) begin
        held     <= held | raise;
        modLevel <= modSet;
      end
      for (int m = 0; m < NUM_MODULES; m++) begin
        if (modWin[m]) begin
          modLevel[m] <= 3'h0;
        end
      end
      if (!ackCycle.valid) begin
        cnt  <= 3'h0;
        lost <= 1'b0;
      end else begin
        cnt <= cnt + 3'h1;
        if (|modWin) begin
          lost <= 1'b1;
        end
      end
      // Released bus inverts its last value every cycle
      extData <= (ackCycle.valid && lvl != 3'h0 && held[lvl]) ? extVec : ~extData;
      if (ackCycle.valid && lvl != 3'h0 && held[lvl] && cnt == dly && !lost && !(|modWin)
          && mode != 2'h2) begin
        extSizeAck        <= (mode == 2'h0);
        autovectorRequest <= (mode == 2'h1);
      end
      if (resultValid && (extSizeAck || autovectorRequest)) begin
        extSizeAck        <= 1'b0;
        autovectorRequest <= 1'b0;
        held[lvl]         <= 1'b0;
      end
    end
  end
endmodule

/* tb/ipa_arbiter_tb.sv */
/*
  Bench for the interrupt priority arbiter: AHB-Lite register tasks and
  acknowledge service checks. Assumes the requester model in tb/.
*/
`timescale 1ns/10ps
module ipa_arbiter_tb;
  import ipa_pkg::*;
  logic                 clock = 1'b0, rst_n = 1'b0, hready, hwrite = 1'b0, hsel = 1'b0;
  logic                 boundary = 1'b0, periodicReq = 1'b0, go = 1'b0, dropAll = 1'b0;
  logic                 extSizeAck, autovectorRequest, resultValid, hresp;
  logic [31:0]          haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]           htrans = 2'h0, mode = 2'h0;
  logic [2:0]           dly = 3'h2, priorityMask;
  logic [7:1]           raise = '0, extIrq_n, pendingLevels;
  logic [3:0][2:0]      modSet = '0, modLevel;
  logic [3:0][7:0]      modVector;
  logic [3:0]           modWin;
  logic [7:0]           extData;
  ipa_ack_cycle_s       ackCycle;
  ipa_result_s          result;
  int                   failures = 0, n_checks = 0;

  always #10 clock = ~clock;

  ipa_arbiter #(.TIMEOUT(6)) uut (.clock(clock), .rst_n(rst_n), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(hsel), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .extIrq_n(extIrq_n),
    .modLevel(modLevel), .modVector(modVector), .periodicReq(periodicReq),
    .periodicVector(8'h77), .boundary(boundary), .extSizeAck(extSizeAck),
    .autovectorRequest(autovectorRequest), .extData(extData), .ackCycle(ackCycle),
    .result(result), .resultValid(resultValid), .modWin(modWin),
    .pendingLevels(pendingLevels), .priorityMask(priorityMask));

  ipa_req_model peer (.clock(clock), .rst_n(rst_n), .go(go), .dropAll(dropAll),
    .raise(raise), .modSet(modSet), .mode(mode), .dly(dly), .extVec(8'h55),
    .ackCycle(ackCycle), .resultValid(resultValid), .modWin(modWin), .extIrq_n(extIrq_n),
    .modLevel(modLevel), .modVector(modVector), .extSizeAck(extSizeAck),
    .autovectorRequest(autovectorRequest), .extData(extData));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task rdy;
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1) begin
      chk("hready", 1, hready);
      end_of_test;
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    rdy;
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    rdy;
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask

  task req(input logic [7:1] r, input logic [3:0][2:0] m);
    raise  <= r;
    modSet <= m;
    go     <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    // Pins pass the two-period filter, level seven also its edge latch
    repeat (3) @(posedge clock);
  endtask

  // Level zero means no acknowledge may start
  task svc(input logic [2:0] lv, input logic [10:0] r);
    int             i;
    ipa_ack_cycle_s ac;
    logic [3:0]     mw;
    ac = '0;
    mw = '0;
    boundary <= 1'b1;
    @(posedge clock);
    boundary <= 1'b0;
    for (i = 0; i < 40 && resultValid !== 1'b1; i++) begin
      @(posedge clock);
      if (ackCycle.valid === 1'b1) ac = ackCycle;
      if (modWin !== 4'h0) mw = modWin;
    end
    if (lv != 3'h0 && i >= 40) begin
      chk("resultValid", 1, 0);
      end_of_test;
    end
    chk("ack", (lv == 3'h0) ? 0 : {FC_CPU_SPACE, ADDR_HI_ONES, lv, 1'b1}, {ac.fc, ac.addr});
    chk("modWin", (r[10:5] == 6'h28) ? 4'h1 << r[4:3] : 4'h0, mw);
    if (lv != 3'h0) begin
      chk("result", r, result);
      repeat (2) @(posedge clock);
      chk("mask", lv, priorityMask);
    end
    repeat (2) @(posedge clock);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(0, OFS_CCR, 0);
    chk("ccr", 32'hE0, rd);
    bus(0, OFS_ARB, 0);
    chk("arb", 32'hF, rd);
    // One-period low pulse on level two must never turn pending
    raise <= 7'h02;
    go    <= 1'b1;
    @(posedge clock);
    go      <= 1'b0;
    dropAll <= 1'b1;
    @(posedge clock);
    dropAll <= 1'b0;
    @(posedge clock);
    chk("pend", 0, pendingLevels);
    req(7'h04, '0);
    repeat (4) @(posedge clock);
    chk("pend", 7'h04, pendingLevels);
    svc(0, 0);
    bus(1, OFS_CCR, 32'h60);
    svc(0, 0);
    bus(1, OFS_CCR, 32'h40);
    svc(3, {8'h55, 3'b000});
    mode <= 2'h1;
    bus(1, OFS_CCR, 0);
    req(7'h02, '0);
    svc(2, {AUTOVEC_BASE + 8'h2, 3'b010});
    $display("test mask and answer done");
    mode <= 2'h0;
    dly  <= 3'h5;
    req(7'h21, '0);
    svc(6, {8'h55, 3'b000});
    bus(1, OFS_CCR, 0);
    svc(1, {8'h55, 3'b000});
    $display("test priority done");
    mode <= 2'h2;
    bus(1, OFS_PERCTL, 32'h100);
    bus(1, OFS_CCR, 32'hE0);
    req(7'h40, '0);
    svc(7, {SPURIOUS_VEC, 3'b101});
    svc(0, 0);
    bus(1, OFS_CCR, 32'hE0);
    svc(7, {SPURIOUS_VEC, 3'b101});
    $display("test top level done");
    dropAll <= 1'b1;
    mode    <= 2'h0;
    dly     <= 3'h2;
    // Level seven must be gone before the mask write, or it re-raises
    repeat (3) @(posedge clock);
    dropAll <= 1'b0;
    bus(1, OFS_CCR, 0);
    req(0, {3'h0, 3'h0, 3'h0, 3'h5});
    svc(5, {SPURIOUS_VEC, 3'b101});
    dropAll <= 1'b1;
    bus(1, OFS_ARB, 32'h92F);
    dropAll <= 1'b0;
    bus(0, OFS_ARB, 0);
    chk("arb", 32'h92F, rd);
    bus(1, OFS_CCR, 0);
    req(0, {3'h0, 3'h0, 3'h4, 3'h4});
    svc(4, {8'hA1, 3'b000});
    bus(1, OFS_CCR, 0);
    svc(4, {8'hA0, 3'b000});
    req(7'h10, {3'h0, 3'h0, 3'h5, 3'h0});
    svc(5, {8'h55, 3'b000});
    bus(1, OFS_CCR, 0);
    svc(5, {8'hA1, 3'b000});
    $display("test arbitration done");
    periodicReq <= 1'b1;
    bus(1, OFS_CCR, 0);
    svc(0, 0);
    bus(1, OFS_PERCTL, 32'h103);
    dly <= 3'h5;
    req(7'h04, '0);
    svc(3, {8'h77, 3'b000});
    periodicReq <= 1'b0;
    bus(1, OFS_CCR, 0);
    svc(3, {8'h55, 3'b000});
    $display("test periodic done");
    end_of_test;
  end
endmodule
